// ===== logic/snp_nrz_byte_port.sv
// serial register port with NRZ receive byte and transmit byte paths
// assumes: rx/tx bit strobes come from baud logic on mclk_in;
// serial pins come from the host and are synchronised here
//
// Operation
// - rx byte ready event every 8 bits
// - unread byte overwritten raises overrun event
// - read command returns one rx reply byte
// - first received bit is first replied
// - rx byte and level registers untouched by reset
// - tx command loads byte into buffer
// - tx bits sent in host order, uninverted
// - first byte starts tx, ready event
// - tx ready event every 8 bits sent
// - no byte in 7 bits ends tx
// - gain command writes level register
// - bits 2..0 pick output level
// - bit 3 boosts bit before level change
// - reply bytes shifted out msb first
// - data sampled on serial clock rising edge
// - each byte acted on at last bit
// - either serial clock idle polarity works
module snp_nrz_byte_port #(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic               mclk_in,
    input  wire logic               srst_in,
    // host serial bus pins
    input  wire logic               sclk_in,
    input  wire logic               cs_n_in,
    input  wire logic               cmd_data_in,
    output logic                    reply_data_out,
    output logic                    reply_oe_n_out,
    input  wire logic               dev_sel_in,
    // receive path from the data slicer
    input  wire logic               rx_bit_in,
    input  wire logic               rx_bit_strobe_in,
    // transmit path
    input  wire logic               tx_enable_in,
    input  wire logic               tx_bit_tick_in,
    output logic                    tx_data_out,
    output logic                    tx_active_out,
    output snp_pkg::snp_level_type  tx_level_out,
    output snp_pkg::snp_event_type  events_out
);
    initial begin
        if (BUF_DEPTH < 2) begin
            $error("snp_nrz_byte_port: BUF_DEPTH must be at least 2");
        end
    end
    // ----------
    // pin synchronisers
    // ----------
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic       sclk_prev_ff;
    logic       sclk_s;
    logic       cs_n_s;
    logic       cmd_s;
    logic       sel_s;
    logic       sclk_rise;
    // first stage is read only by the second
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sync1_ff     <= 4'h1;
            sync2_ff     <= 4'h1;
            sclk_prev_ff <= 1'b0;
        end else begin
            sync1_ff     <= {dev_sel_in, cmd_data_in, sclk_in, cs_n_in};
            sync2_ff     <= sync1_ff;
            sclk_prev_ff <= sync2_ff[1];
        end
    end
    assign cs_n_s    = sync2_ff[0];
    assign sclk_s    = sync2_ff[1];
    assign cmd_s     = sync2_ff[2];
    assign sel_s     = sync2_ff[3];
    // only rising edges matter, so an idle-high clock needs no setup
    assign sclk_rise = sclk_s & ~sclk_prev_ff & ~cs_n_s;
    // ----------
    // address decode
    // ----------
    logic [7:0] ofs;
    logic [7:0] ac_rd;
    logic [7:0] ac_tx;
    logic [7:0] ac_gain;
    assign ofs     = sel_s ? snp_pkg::AC_DEV2_OFS : 8'h00;
    assign ac_rd   = snp_pkg::AC_READ_RX | ofs;
    assign ac_tx   = snp_pkg::AC_WRITE_TX | ofs;
    assign ac_gain = snp_pkg::AC_WRITE_GAIN | ofs;
    // ----------
    // serial port state machine
    // ----------
    snp_pkg::snp_port_state_type state_ff;
    snp_pkg::snp_target_type     target_ff;
    logic [2:0]                  bit_cnt_ff;
    logic [7:0]                  cmd_sh_ff;
    logic [7:0]                  cmd_byte;
    logic                        byte_done;
    logic                        rd_take;
    logic                        tx_load;
    logic                        gain_load;
    assign cmd_byte  = {cmd_sh_ff[6:0], cmd_s};
    assign byte_done = sclk_rise && (bit_cnt_ff == snp_pkg::LAST_BIT_IDX);
    // commands fire on their own last bit, not at deselect
    assign rd_take   = byte_done && (state_ff == snp_pkg::ST_ADDR) && (cmd_byte == ac_rd);
    assign tx_load   = byte_done && (state_ff == snp_pkg::ST_DATA) && (target_ff == snp_pkg::TGT_TX);
    assign gain_load = byte_done && (state_ff == snp_pkg::ST_DATA) && (target_ff == snp_pkg::TGT_GAIN);
    // bit counter and command shifter
    always_ff @(posedge mclk_in) begin
        if (srst_in || cs_n_s) begin
            bit_cnt_ff <= 3'h0;
            cmd_sh_ff  <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            cmd_sh_ff  <= cmd_byte;
        end
    end
    // transaction sequencing
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_ff  <= snp_pkg::ST_IDLE;
            target_ff <= snp_pkg::TGT_TX;
        end else if (cs_n_s) begin
            state_ff  <= snp_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                snp_pkg::ST_IDLE: begin
                    state_ff <= snp_pkg::ST_ADDR;
                end
                snp_pkg::ST_ADDR: begin
                    if (byte_done) begin
                        if (cmd_byte == ac_rd) begin
                            state_ff <= snp_pkg::ST_REPLY;
                        end else if (cmd_byte == ac_tx) begin
                            state_ff  <= snp_pkg::ST_DATA;
                            target_ff <= snp_pkg::TGT_TX;
                        end else if (cmd_byte == ac_gain) begin
                            state_ff  <= snp_pkg::ST_DATA;
                            target_ff <= snp_pkg::TGT_GAIN;
                        end else begin
                            state_ff <= snp_pkg::ST_DONE;  // other addresses are not ours
                        end
                    end
                end
                snp_pkg::ST_DATA, snp_pkg::ST_REPLY: begin
                    if (byte_done) begin
                        state_ff <= snp_pkg::ST_DONE;  // exactly one data or reply byte
                    end
                end
                snp_pkg::ST_DONE: begin
                    state_ff <= snp_pkg::ST_DONE;
                end
                default: begin
                    state_ff <= snp_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // ----------
    // receive byte assembly
    // ----------
    logic [2:0] rx_cnt_ff;
    logic [7:0] rx_sh_ff;
    logic [7:0] rx_byte_ff;
    logic       rx_full_ff;
    logic       rx_done;
    assign rx_done = rx_bit_strobe_in && (rx_cnt_ff == snp_pkg::LAST_BIT_IDX);
    // no byte alignment: every eighth bit closes a byte
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rx_cnt_ff <= 3'h0;
        end else if (rx_bit_strobe_in) begin
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
        end
    end
    // data registers carry no reset and keep contents over it
    always_ff @(posedge mclk_in) begin
        if (rx_bit_strobe_in) begin
            rx_sh_ff <= {rx_sh_ff[6:0], rx_bit_in};
        end
        if (rx_done) begin
            rx_byte_ff <= {rx_sh_ff[6:0], rx_bit_in};
        end
    end
    // unread flag; a new byte wins over a read in the same cycle
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rx_full_ff <= 1'b0;
        end else if (rx_done) begin
            rx_full_ff <= 1'b1;
        end else if (rd_take) begin
            rx_full_ff <= 1'b0;
        end
    end
    // ----------
    // reply shifter
    // ----------
    logic [7:0] reply_sh_ff;
    // msb is presented before the first rising edge and moves after each but the last, where the output is released
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            reply_sh_ff    <= 8'h00;
            reply_data_out <= 1'b0;
            reply_oe_n_out <= 1'b1;
        end else if (rd_take) begin
            reply_sh_ff    <= {rx_byte_ff[6:0], 1'b0};
            reply_data_out <= rx_byte_ff[7];
            reply_oe_n_out <= 1'b0;
        end else if (state_ff == snp_pkg::ST_REPLY && !cs_n_s && !byte_done) begin
            if (sclk_rise) begin
                reply_sh_ff    <= {reply_sh_ff[6:0], 1'b0};
                reply_data_out <= reply_sh_ff[7];
            end
        end else begin
            reply_oe_n_out <= 1'b1;
        end
    end
    // ----------
    // level and emphasis register
    // ----------
    logic [2:0] level_ff;
    logic       emph_ff;
    // upper four bits are dropped; code 111 is passed on unchanged
    always_ff @(posedge mclk_in) begin
        if (gain_load) begin
            level_ff <= cmd_byte[snp_pkg::GAIN_LEVEL_MSB:0];
            emph_ff  <= cmd_byte[snp_pkg::GAIN_EMPH_BIT];
        end
    end
    // ----------
    // transmit buffer and serializer
    // ----------
    logic       buf_in_ready;
    logic [7:0] buf_data;
    logic       buf_valid;
    logic       tx_take;
    logic       tx_run_ff;
    logic [2:0] tx_cnt_ff;
    logic [7:0] tx_sh_ff;
    logic       tx_start;
    logic       tx_next;
    logic       tx_starve;
    logic       cur_bit;
    logic       next_bit;
    snp_byte_buffer #(
        .WIDTH (snp_pkg::BYTE_BITS),
        .DEPTH (BUF_DEPTH)
    ) u_tx_buf (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .in_data_in    (cmd_byte),
        .in_valid_in   (tx_load),
        .in_ready_out  (buf_in_ready),
        .out_data_out  (buf_data),
        .out_valid_out (buf_valid),
        .out_ready_in  (tx_take)
    );
    assign tx_start  = !tx_run_ff && tx_enable_in && buf_valid;
    assign tx_next   = tx_run_ff && tx_bit_tick_in && (tx_cnt_ff == snp_pkg::LAST_BIT_IDX) && buf_valid;
    // starving at the seventh period stops tx before the byte's tail
    assign tx_starve = tx_run_ff && tx_bit_tick_in && (tx_cnt_ff == snp_pkg::UNDERRUN_IDX) && !buf_valid;
    assign tx_take   = tx_start || tx_next;
    assign cur_bit   = tx_take ? buf_data[7] : tx_sh_ff[6];
    assign next_bit  = tx_take ? buf_data[6] :
                       (tx_cnt_ff == snp_pkg::UNDERRUN_IDX) ? buf_data[7] : tx_sh_ff[5];
    // run control and bit position
    always_ff @(posedge mclk_in) begin
        if (srst_in || !tx_enable_in || tx_starve) begin
            tx_run_ff <= 1'b0;
            tx_cnt_ff <= 3'h0;
        end else if (tx_take) begin
            tx_run_ff <= 1'b1;
            tx_cnt_ff <= 3'h0;
        end else if (tx_run_ff && tx_bit_tick_in) begin
            tx_cnt_ff <= tx_cnt_ff + 3'h1;
        end
    end
    // bit shifter, first host bit leaves first, not inverted
    always_ff @(posedge mclk_in) begin
        if (tx_take) begin
            tx_sh_ff <= buf_data;
        end else if (tx_run_ff && tx_bit_tick_in) begin
            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
        end
    end
    // line outputs; inactive means the analog stage sits at bias
    always_ff @(posedge mclk_in) begin
        if (srst_in || !tx_enable_in || tx_starve) begin
            tx_data_out   <= 1'b0;
            tx_active_out <= 1'b0;
        end else if (tx_take || (tx_run_ff && tx_bit_tick_in)) begin
            tx_data_out   <= cur_bit;
            tx_active_out <= 1'b1;
        end
    end
    // level and boost; boost only where the following bit differs
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            tx_level_out <= '{level: snp_pkg::GAIN_LEVEL_RST, boost: 1'b0};
        end else begin
            tx_level_out.level <= level_ff;
            if (tx_take || (tx_run_ff && tx_bit_tick_in)) begin
                tx_level_out.boost <= emph_ff && (cur_bit != next_bit);
            end else if (!tx_run_ff) begin
                tx_level_out.boost <= 1'b0;
            end
        end
    end
    // ----------
    // event pulses
    // ----------
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            events_out <= '0;
        end else begin
            events_out.rx_ready    <= rx_done;
            events_out.rx_overrun  <= rx_done && rx_full_ff;
            events_out.tx_ready    <= tx_take;
            events_out.tx_underrun <= tx_starve;
            events_out.tx_refused  <= tx_load && !buf_in_ready;
        end
    end

endmodule : snp_nrz_byte_port

// ===== common/snp_pkg.sv
// constants, field layout and carrier types of the serial byte port
// assumes: compiled before every design file that names it
package snp_pkg;

    // ----------
    // address/command bytes
    // ----------
    localparam logic [7:0] AC_READ_RX    = 8'h74;
    localparam logic [7:0] AC_WRITE_TX   = 8'h75;
    localparam logic [7:0] AC_WRITE_GAIN = 8'h76;
    localparam logic [7:0] AC_DEV2_OFS   = 8'h08;  // second device answers base plus this

    // ----------
    // field layout of the level/emphasis byte
    // ----------
    localparam int          GAIN_LEVEL_MSB = 2;
    localparam int          GAIN_EMPH_BIT  = 3;
    localparam logic [2:0]  GAIN_LEVEL_RST = 3'h3;  // 0 dB only while reset is held; after it the level register is output

    // ----------
    // counts
    // ----------
    localparam int          BYTE_BITS     = 8;
    localparam logic [2:0]  LAST_BIT_IDX  = 3'h7;
    localparam logic [2:0]  UNDERRUN_IDX  = 3'h6;   // seventh bit period ends here
    localparam int          SYNC_STAGES   = 2;

    // ----------
    // serial port states, one-hot
    // ----------
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_ADDR  = 5'h02,
        ST_DATA  = 5'h04,
        ST_REPLY = 5'h08,
        ST_DONE  = 5'h10
    } snp_port_state_type;

    typedef enum logic [1:0] {
        TGT_TX   = 2'h1,
        TGT_GAIN = 2'h2
    } snp_target_type;

    // one-cycle event pulses toward the interrupt logic
    typedef struct packed {
        logic rx_ready;
        logic rx_overrun;
        logic tx_ready;
        logic tx_underrun;
        logic tx_refused;
    } snp_event_type;

    // transmit level and emphasis toward the analog stage
    typedef struct packed {
        logic [2:0] level;
        logic       boost;
    } snp_level_type;

endpackage : snp_pkg

// ===== logic/snp_byte_buffer.sv
// small first-in first-out buffer with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
module snp_byte_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             mclk_in,
    input  wire logic             srst_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin
            $error("snp_byte_buffer: DEPTH must be a power of two >= 2");
        end
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count_ff != DEPTH[AW:0]);
    assign out_valid_out = (count_ff != '0);
    assign out_data_out  = mem_ff[rd_ptr_ff];
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;

    // storage holds no reset: contents are undefined until written
    always_ff @(posedge mclk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    // pointers and fill level
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

endmodule : snp_byte_buffer

// ===== verification/snp_host_model.sv
// host model driving the chip-select serial bus of the byte port
// assumes: one frame at a time, called from the bench through frame
module snp_host_model (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      cmd_data_out,
    input  wire logic reply_data_in,
    input  wire logic reply_oe_n_in
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------
    // bus idle, serial clock stands still outside frames
    // ----------
    initial begin
        sclk_out     = 1'b0;
        cs_n_out     = 1'b1;
        cmd_data_out = 1'b0;
    end

    // address byte then exactly one command or reply byte
    task automatic frame(input logic idle_hi, input logic [7:0] ac, input logic [7:0] dat,
                         output logic [7:0] rep, output logic drove);
        logic [15:0] sh;
        sh       = {ac, dat};
        rep      = 8'h00;
        drove    = 1'b0;
        sclk_out = idle_hi;
        #307;
        cs_n_out = 1'b0;
        #400;
        for (int i = 15; i >= 0; i--) begin
            sclk_out     = 1'b0;
            cmd_data_out = sh[i];
            #100;
            sclk_out = 1'b1;
            if (i < 8) begin
                rep   = {rep[6:0], reply_data_in};
                drove = drove | ~reply_oe_n_in;
            end
            #100;
        end
        sclk_out = idle_hi;
        #200;
        cs_n_out     = 1'b1;
        cmd_data_out = ~cmd_data_out; // a released line never keeps its value
        #600;
    endtask : frame
endmodule : snp_host_model

// ===== verification/snp_port_chk_chk.sv
// concurrent checks on the serial byte port, seeing its ports only
// assumes: bound onto snp_nrz_byte_port, single clock domain mclk_in
module snp_port_chk #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic              mclk_in,
    input wire logic              srst_in,
    input wire logic              sclk_in,
    input wire logic              cs_n_in,
    input wire logic              reply_data_out,
    input wire logic              reply_oe_n_out,
    input wire logic              rx_bit_strobe_in,
    input wire logic              tx_enable_in,
    input wire logic              tx_bit_tick_in,
    input wire logic              tx_data_out,
    input wire logic              tx_active_out,
    input snp_pkg::snp_event_type events_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    logic [2:0] strobe_cnt_ff;
    logic       sclk_prev_ff;
    logic [2:0] quiet_ff;
    logic       byte_close;

    // ----------
    // helper logic
    // ----------
    // strobes counted modulo one byte, no alignment beyond reset
    assign byte_close = rx_bit_strobe_in && (strobe_cnt_ff == 3'h7);
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            strobe_cnt_ff <= 3'h0;
        end else if (rx_bit_strobe_in) begin
            strobe_cnt_ff <= strobe_cnt_ff + 3'h1;
        end
    end

    // cycles since the serial clock pin last moved, saturating
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            sclk_prev_ff <= 1'b0;
            quiet_ff     <= 3'h0;
        end else begin
            sclk_prev_ff <= sclk_in;
            if (sclk_in != sclk_prev_ff) begin
                quiet_ff <= 3'h0;
            end else if (quiet_ff != 3'h7) begin
                quiet_ff <= quiet_ff + 3'h1;
            end
        end
    end

    sequence s_byte_close;
        byte_close;
    endsequence
    sequence s_cs_idle;
        cs_n_in [*5];
    endsequence
    // sync delay is at most four cycles, so six quiet cycles are safe
    sequence s_reply_quiet;
        !reply_oe_n_out && !$past(reply_oe_n_out) && (quiet_ff >= 3'h6);
    endsequence

    a_rx_ready_eight: assert property (s_byte_close |=> events_out.rx_ready)
        else $error("rx ready missing after eighth strobe");
    a_rx_ready_cause: assert property (events_out.rx_ready |-> $past(byte_close))
        else $error("rx ready without a closed byte");
    a_overrun_with_ready: assert property (events_out.rx_overrun |-> events_out.rx_ready)
        else $error("overrun outside a byte close");
    a_tx_idle_zero: assert property (!tx_active_out |-> !tx_data_out)
        else $error("tx data not at bias while inactive");
    a_tx_shift_tick: assert property ($changed(tx_data_out) && tx_active_out && $past(tx_active_out)
        |-> $past(tx_bit_tick_in))
        else $error("tx bit moved without a tick");
    a_tx_start_ready: assert property ($rose(tx_active_out) |-> events_out.tx_ready && $past(tx_enable_in))
        else $error("tx start without ready or enable");
    a_underrun_stop: assert property (events_out.tx_underrun |-> !tx_active_out)
        else $error("tx still active at underrun");
    a_reply_release: assert property (s_cs_idle |-> reply_oe_n_out)
        else $error("reply driven while deselected");
    a_reply_steady: assert property (s_reply_quiet |-> $stable(reply_data_out))
        else $error("reply bit moved without clock edge");
endmodule : snp_port_chk

// ===== verification/testbench.sv
// self-checking bench for the serial byte port with a host bus model
// assumes: package, design, host model and checker compiled before it
module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                   mclk_in;
    logic                   srst_in     = 1'b1;
    logic                   dev_sel     = 1'b0;
    logic                   rx_bit      = 1'b0;
    logic                   rx_strobe   = 1'b0;
    logic                   tx_enable   = 1'b0;
    logic                   tx_tick     = 1'b0;
    logic                   sclk, cs_n, cmd_data, reply_data, reply_oe_n, tx_data, tx_active, drove;
    logic [7:0]             rep;
    snp_pkg::snp_level_type tx_level;
    snp_pkg::snp_event_type events;
    int                     n_mismatch  = 0;
    int                     check_count = 0;
    int                     cycles      = 0;
    int                     n_rxr = 0, n_ovr = 0, n_txr = 0, n_und = 0, n_ref = 0;

    snp_nrz_byte_port dut_u (.mclk_in(mclk_in), .srst_in(srst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .cmd_data_in(cmd_data), .reply_data_out(reply_data), .reply_oe_n_out(reply_oe_n), .dev_sel_in(dev_sel),
        .rx_bit_in(rx_bit), .rx_bit_strobe_in(rx_strobe), .tx_enable_in(tx_enable), .tx_bit_tick_in(tx_tick),
        .tx_data_out(tx_data), .tx_active_out(tx_active), .tx_level_out(tx_level), .events_out(events));
    snp_host_model host_u (.sclk_out(sclk), .cs_n_out(cs_n), .cmd_data_out(cmd_data),
        .reply_data_in(reply_data), .reply_oe_n_in(reply_oe_n));

    // ----------
    // clock, event tally and hang guard
    // ----------
    initial begin
        mclk_in = 1'b0;
        forever #12.5 mclk_in = ~mclk_in;
    end

    // pulses last one cycle, so they are tallied rather than polled
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (events.rx_ready === 1'b1) n_rxr <= n_rxr + 1;
        if (events.rx_overrun === 1'b1) n_ovr <= n_ovr + 1;
        if (events.tx_ready === 1'b1) n_txr <= n_txr + 1;
        if (events.tx_underrun === 1'b1) n_und <= n_und + 1;
        if (events.tx_refused === 1'b1) n_ref <= n_ref + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            results();
        end
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic xfer(input logic idle_hi, input logic [7:0] ac, input logic [7:0] dat);
        host_u.frame(idle_hi, ac, dat, rep, drove);
    endtask : xfer

    // first bit on the line is the byte's msb
    task automatic rx_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk_in);
            rx_bit    <= b[i];
            rx_strobe <= 1'b1;
            @(posedge mclk_in);
            rx_strobe <= 1'b0;
        end
        repeat (3) @(posedge mclk_in);
    endtask : rx_byte

    // ----------
    // scenarios
    // ----------
    task automatic test_gain();
        for (int c = 0; c < 8; c++) begin
            xfer(1'b0, snp_pkg::AC_WRITE_GAIN, 8'(c));
            chk("gain level", 8'(c), 8'(tx_level.level));
        end
        @(posedge mclk_in);
        dev_sel <= 1'b1;
        fork
            xfer(1'b1, snp_pkg::AC_WRITE_GAIN + snp_pkg::AC_DEV2_OFS, 8'h05);
            #4050 chk("gain level while selected", 8'h05, {cs_n, 4'h0, tx_level.level});
        join
        xfer(1'b0, snp_pkg::AC_WRITE_GAIN, 8'h02);
        chk("foreign gain write", 8'h05, 8'(tx_level.level));
        @(posedge mclk_in);
        dev_sel <= 1'b0;
        $display("test gain done");
    endtask : test_gain

    task automatic test_rx();
        rx_byte(8'hB4);
        chk("rx ready count", 8'h01, 8'(n_rxr));
        xfer(1'b0, snp_pkg::AC_READ_RX, 8'h00);
        chk("rx reply", 8'hB4, rep);
        chk("rx reply driven", 8'h01, 8'(drove));
        xfer(1'b1, snp_pkg::AC_READ_RX, 8'h00);
        chk("rx reply idle high clock", 8'hB4, rep);
        rx_byte(8'h1E);
        rx_byte(8'h69);
        chk("rx overrun count", 8'h01, 8'(n_ovr));
        @(posedge mclk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        xfer(1'b0, snp_pkg::AC_READ_RX, 8'h00);
        chk("rx byte after reset", 8'h69, rep);
        chk("level after reset", 8'h05, 8'(tx_level.level));
        xfer(1'b0, 8'h77, 8'h00);
        chk("unknown address driven", 8'h00, 8'(drove));
        @(posedge mclk_in);
        dev_sel <= 1'b1;
        xfer(1'b0, snp_pkg::AC_READ_RX + snp_pkg::AC_DEV2_OFS, 8'h00);
        chk("second device reply", 8'h69, rep);
        @(posedge mclk_in);
        dev_sel <= 1'b0;
        $display("test rx done");
    endtask : test_rx

    // two bytes fill the buffer, a third is refused, then drain to underrun
    task automatic test_tx();
        logic [14:0] bits;
        bits = {8'hC5, 7'h1D};
        xfer(1'b0, snp_pkg::AC_WRITE_GAIN, 8'h0B);
        xfer(1'b0, snp_pkg::AC_WRITE_TX, 8'hC5);
        xfer(1'b0, snp_pkg::AC_WRITE_TX, 8'h3A);
        xfer(1'b0, snp_pkg::AC_WRITE_TX, 8'hFF);
        chk("tx refused count", 8'h01, 8'(n_ref));
        @(posedge mclk_in);
        tx_enable <= 1'b1;
        for (int w = 0; w < 20 && tx_active !== 1'b1; w++) @(posedge mclk_in);
        #1 chk("tx ready at start", 8'h01, 8'(n_txr));
        for (int i = 14; i >= 0; i--) begin
            repeat (3) @(posedge mclk_in);
            #1;
            chk("tx bit", 8'(bits[i]), 8'(tx_data));
            if (i > 0) chk("tx boost", 8'(bits[i] ^ bits[i-1]), 8'(tx_level.boost));
            @(posedge mclk_in);
            tx_tick <= 1'b1;
            @(posedge mclk_in);
            tx_tick <= 1'b0;
        end
        repeat (3) @(posedge mclk_in);
        chk("tx ready count", 8'h02, 8'(n_txr));
        chk("tx underrun count", 8'h01, 8'(n_und));
        chk("tx active after underrun", 8'h00, 8'(tx_active));
        tx_enable <= 1'b0;
        xfer(1'b0, snp_pkg::AC_WRITE_GAIN, 8'h03);
        $display("test tx done");
    endtask : test_tx

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        repeat (8) @(posedge mclk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        test_gain();
        test_rx();
        test_tx();
        results();
    end
endmodule : testbench

bind snp_nrz_byte_port snp_port_chk #(.BUF_DEPTH(BUF_DEPTH)) chk_u (.mclk_in(mclk_in), .srst_in(srst_in),
    .sclk_in(sclk_in), .cs_n_in(cs_n_in), .reply_data_out(reply_data_out), .reply_oe_n_out(reply_oe_n_out),
    .rx_bit_strobe_in(rx_bit_strobe_in), .tx_enable_in(tx_enable_in), .tx_bit_tick_in(tx_bit_tick_in),
    .tx_data_out(tx_data_out), .tx_active_out(tx_active_out), .events_out(events_out));
